// *** core/sdd_pkg.sv ***
/*
 Shared constants of the step and direction input decoder: register map,
 field positions, reset values and input timing figures.
 Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package sdd_pkg;

	// Clock rate in kHz, used to derive cycle counts from times
	localparam int unsigned SDD_CLK_KHZ = 40000;

	// Register byte offsets
	localparam logic [7:0] SDD_CTRL_OFS = 8'h00;
	localparam logic [7:0] SDD_STAT_OFS = 8'h04;
	localparam logic [7:0] SDD_CW_CNT_OFS = 8'h08;
	localparam logic [7:0] SDD_CCW_CNT_OFS = 8'h0c;

	// Control register field positions
	localparam int unsigned SDD_CTRL_MODE_BIT = 0;
	localparam int unsigned SDD_CTRL_EDGE_BIT = 1;
	localparam int unsigned SDD_CTRL_CWLVL_BIT = 2;
	localparam int unsigned SDD_CTRL_CCWLVL_BIT = 3;
	localparam int unsigned SDD_CTRL_SRC_BIT = 4;
	localparam int unsigned SDD_CTRL_CLR_BIT = 5;
	localparam int unsigned SDD_CTRL_WIDTH = 5;

	// Control reset: step/direction, rising edge, high-active pulses, sinking
	localparam logic [SDD_CTRL_WIDTH-1:0] SDD_CTRL_RESET = 5'h0c;

	// Status register field positions
	localparam int unsigned SDD_STAT_ENA_BIT = 0;
	localparam int unsigned SDD_STAT_DIR_BIT = 1;
	localparam int unsigned SDD_STAT_PUL_BIT = 2;

	// Controller timing figures (not checked, documented for reference)
	localparam int unsigned SDD_DIR_LEAD_NS = 5000;
	localparam int unsigned SDD_PULSE_MIN_NS = 2500;
	localparam int unsigned SDD_ENA_LEAD_NS = 5000;
	localparam int unsigned SDD_PULSE_MIN_CYC = (SDD_PULSE_MIN_NS * SDD_CLK_KHZ) / 1000000;

	// Synchroniser depth
	localparam int unsigned SDD_SYNC_STAGES = 3;

	// AHB transfer type
	localparam logic [1:0] SDD_HTRANS_NONSEQ = 2'b10;

	// Mode selection codes
	typedef enum logic
	{
		SDD_STEP_SENSE_MODE = 1'b0,
		SDD_DUAL_PULSE_MODE = 1'b1
	} sdd_mode_t;

endpackage

// *** core/sdd_sync.sv ***
/*
 Three-stage input synchroniser for one pin; the output changes once
 the second and third stages agree.
 Assumes an asynchronous input and a synchronous active-high reset.
*/
module sdd_sync
	import sdd_pkg::*;
(
	input wire logic sys_clk_in, // System clock
	input wire logic sys_rst_in, // Synchronous reset
	input wire logic pin_in, // Asynchronous pin
	input wire logic rst_val_in, // Level assumed during reset
	output logic level_out // Filtered level
);

	logic [SDD_SYNC_STAGES-1:0] stage_reg;
	logic level_reg;
	logic agree;

	// Stages two and three must agree before the level moves
	assign agree = (stage_reg[1] == stage_reg[2]);
	assign level_out = level_reg;

	// Shift chain and qualified level
	always_ff @(posedge sys_clk_in)
	begin
		stage_reg <= {stage_reg[SDD_SYNC_STAGES-2:0], pin_in};
		if (sys_rst_in)
			level_reg <= rst_val_in;
		else if (agree)
			level_reg <= stage_reg[2];
	end

endmodule

// *** core/sdd_edge.sv ***
/*
 Rising and falling edge detector on a synchronised signal.
 Assumes input already on the system clock.
*/
module sdd_edge
	import sdd_pkg::*;
(
	input wire logic sys_clk_in, // System clock
	input wire logic sys_rst_in, // Synchronous reset
	input wire logic level_in, // Synchronised level
	input wire logic rst_val_in, // Idle level after reset
	output logic rise_out, // One-cycle rising edge
	output logic fall_out // One-cycle falling edge
);

	logic prev_reg;

	// Compare with previous level
	assign rise_out = level_in & ~prev_reg;
	assign fall_out = ~level_in & prev_reg;

	// Previous level
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			prev_reg <= rst_val_in;
		else
			prev_reg <= level_in;
	end

endmodule

// *** core/sdd_decoder.sv ***
/*
 Step and direction input decoder: synchronises the three command pins,
 decodes step/direction or dual-pulse commands and gates the drive.
 Registers sit on an AHB-Lite slave. Assumes a 40 MHz clock and that
 the controller honours the documented set-up and pulse width times.
*/
// The AHB-Lite slave port and the address map were chosen for this implementation.
module sdd_decoder
	import sdd_pkg::*;
(
	input wire logic sys_clk_in, // System clock, 40 MHz
	input wire logic sys_rst_in, // Synchronous reset, active high
	input wire logic step_pulse_in, // Step pulse pin
	input wire logic dir_pin_in, // Direction or CCW pulse pin
	input wire logic drive_gate_in, // Drive enable pin
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB ready in
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB ready out
	output logic hresp, // AHB response
	output logic step_out, // One-cycle microstep command
	output logic dir_out, // Rotation sense, 1 is counter-clockwise
	output logic drive_en_out // Drive enabled
);

	logic [SDD_CTRL_WIDTH-1:0] ctrl_reg;
	logic [SDD_CTRL_WIDTH-1:0] ctrl_next;
	logic [15:0] cw_cnt_reg;
	logic [15:0] ccw_cnt_reg;
	logic step_reg;
	logic dir_reg;
	logic en_reg;
	logic wr_pend_reg;
	logic [7:0] addr_reg;
	logic [31:0] rdata_reg;
	logic pul_s;
	logic dir_s;
	logic ena_s;
	logic pul_rise;
	logic pul_fall;
	logic dir_rise;
	logic dir_fall;
	logic mode_dual;
	logic edge_fall;
	logic src_type;
	logic cw_lvl;
	logic ccw_lvl;
	logic pul_active_edge;
	logic cw_evt;
	logic ccw_evt;
	logic sense_evt;
	logic step_evt;
	logic dir_next;
	logic en_next;
	logic acc;
	logic wr_ctrl;
	logic cnt_clr;
	logic [31:0] rd_mux;

	// Register select from the low address byte
	function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [31:0] ct,
		input logic [31:0] st, input logic [31:0] cw, input logic [31:0] ccw);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			SDD_CTRL_OFS: r = ct;
			SDD_STAT_OFS: r = st;
			SDD_CW_CNT_OFS: r = cw;
			SDD_CCW_CNT_OFS: r = ccw;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// Pin synchronisers and edge detectors
	sdd_sync u_sync_pul (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.pin_in(step_pulse_in), .rst_val_in(1'b0), .level_out(pul_s));
	sdd_sync u_sync_dir (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.pin_in(dir_pin_in), .rst_val_in(1'b0), .level_out(dir_s));
	sdd_sync u_sync_ena (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.pin_in(drive_gate_in), .rst_val_in(1'b0), .level_out(ena_s));
	sdd_edge u_edge_pul (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.level_in(pul_s), .rst_val_in(1'b0), .rise_out(pul_rise), .fall_out(pul_fall));
	sdd_edge u_edge_dir (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.level_in(dir_s), .rst_val_in(1'b0), .rise_out(dir_rise), .fall_out(dir_fall));

	// Configuration fields
	assign mode_dual = ctrl_reg[SDD_CTRL_MODE_BIT];
	assign edge_fall = ctrl_reg[SDD_CTRL_EDGE_BIT];
	assign cw_lvl = ctrl_reg[SDD_CTRL_CWLVL_BIT];
	assign ccw_lvl = ctrl_reg[SDD_CTRL_CCWLVL_BIT];
	assign src_type = ctrl_reg[SDD_CTRL_SRC_BIT];

	// Effective edge flips for sourcing inputs
	assign pul_active_edge = (edge_fall ^ src_type) ? pul_fall : pul_rise;
	assign sense_evt = ~mode_dual & pul_active_edge;
	// Dual pulse: a pulse counts when it goes to its active level
	assign cw_evt = mode_dual & (cw_lvl ? pul_rise : pul_fall);
	assign ccw_evt = mode_dual & (ccw_lvl ? dir_rise : dir_fall) & ~cw_evt;
	assign step_evt = sense_evt | cw_evt | ccw_evt;

	// Direction: level in step sense mode, pulse source in dual mode
	assign dir_next = mode_dual ? (ccw_evt ? 1'b1 : (cw_evt ? 1'b0 : dir_reg))
		: dir_s;
	assign en_next = ena_s ^ src_type;

	// Command outputs
	assign step_out = step_reg;
	assign dir_out = dir_reg;
	assign drive_en_out = en_reg;

	// Command registers, direction presented with its step
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			step_reg <= 1'b0;
			dir_reg <= 1'b0;
			en_reg <= 1'b0;
		end
		else
		begin
			step_reg <= step_evt & en_next;
			dir_reg <= dir_next;
			en_reg <= en_next;
		end
	end

	// Step counters per direction, software clears, counting wins
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			cw_cnt_reg <= 16'h0;
			ccw_cnt_reg <= 16'h0;
		end
		else
		begin
			if (step_reg & ~dir_reg)
				cw_cnt_reg <= cw_cnt_reg + 16'h1;
			else if (cnt_clr)
				cw_cnt_reg <= 16'h0;
			if (step_reg & dir_reg)
				ccw_cnt_reg <= ccw_cnt_reg + 16'h1;
			else if (cnt_clr)
				ccw_cnt_reg <= 16'h0;
		end
	end

	// Bus decode: address phase for reads, data phase for control writes
	assign acc = hsel & hready & (htrans == SDD_HTRANS_NONSEQ);
	assign wr_ctrl = wr_pend_reg & (addr_reg == SDD_CTRL_OFS);
	assign cnt_clr = wr_ctrl & hwdata[SDD_CTRL_CLR_BIT];
	assign ctrl_next = wr_ctrl ? hwdata[SDD_CTRL_WIDTH-1:0] : ctrl_reg;
	assign rd_mux = reg_read(haddr[7:0], {27'h0, ctrl_reg},
		{29'h0, pul_s, dir_reg, en_reg}, {16'h0, cw_cnt_reg}, {16'h0, ccw_cnt_reg});

	// Zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	// Bus pipeline and control register
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			ctrl_reg <= SDD_CTRL_RESET;
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h0;
			rdata_reg <= 32'h0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			wr_pend_reg <= acc & hwrite;
			if (acc)
				addr_reg <= haddr[7:0];
			if (acc & ~hwrite)
				rdata_reg <= rd_mux;
		end
	end

endmodule

// *** tb/sdd_ctl_model.sv ***
/* Motion controller model driving the step, direction and gate pins.
 Assumes the decoder samples these pins on its own clock. */
module sdd_ctl_model
(
	input wire logic clk_in, // Clock
	output logic step_out, // Step pin
	output logic dir_out, // Direction pin
	output logic gate_out // Gate pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// Hold exceeds the 5 us leads and 2.5 us width at 40 MHz
	localparam int HOLD = 210;
	initial {step_out, dir_out, gate_out} = 3'h0;
	// Move one pin, then keep every pin still for the hold time
	task automatic set_pin(input int p, input logic v);
		@(posedge clk_in);
		case (p)
			0: step_out <= v;
			1: dir_out <= v;
			default: gate_out <= v;
		endcase
		repeat (HOLD) @(posedge clk_in);
	endtask
endmodule

// *** tb/sdd_decoder_asserts.sv ***
/* Port checker of the step and direction decoder.
 Bound to every decoder instance; one clock domain. */
module sdd_decoder_asserts
(
	input wire logic sys_clk_in, // Clock
	input wire logic sys_rst_in, // Reset
	input wire logic step_pulse_in, // Step pin
	input wire logic dir_pin_in, // Direction pin
	input wire logic drive_gate_in, // Gate pin
	input wire logic hsel, // Select
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic hready, // Ready in
	input wire logic [31:0] hrdata, // Read data
	input wire logic hreadyout, // Ready out
	input wire logic hresp, // Response
	input wire logic step_out, // Step command
	input wire logic drive_en_out // Drive enable
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] calm_reg;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Cycles since the gate pin moved or a write was issued
	always_ff @(posedge sys_clk_in)
		if (sys_rst_in || $changed(drive_gate_in) || (hsel && hwrite))
			calm_reg <= 4'h0;
		else if (calm_reg != 4'hf)
			calm_reg <= calm_reg + 4'h1;
	a_ready_const: assert property (hreadyout) else $error("ready low");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_step_single: assert property (step_out |=> !step_out) else $error("long step");
	a_step_gated: assert property (step_out |-> drive_en_out) else $error("step disabled");
	a_quiet_pins: assert property (($stable(step_pulse_in) && $stable(dir_pin_in))[*8]
		|-> !step_out) else $error("step without pin edge");
	a_en_calm: assert property (calm_reg == 4'hf |-> $stable(drive_en_out))
		else $error("enable moved alone");
	a_rst_clear: assert property (disable iff (1'b0) sys_rst_in
		|=> !step_out && !drive_en_out && hrdata == 32'h0) else $error("reset state");
	a_rdata_cause: assert property ($changed(hrdata)
		|-> $past(hsel && hready && htrans == 2'b10 && !hwrite)) else $error("read data moved");
endmodule

bind sdd_decoder sdd_decoder_asserts u_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.step_pulse_in(step_pulse_in), .dir_pin_in(dir_pin_in), .drive_gate_in(drive_gate_in),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .step_out(step_out), .drive_en_out(drive_en_out));

// *** tb/tb_sdd_decoder.sv ***
/* Self-checking bench of the step and direction decoder.
 Assumes the controller model and the bound checker. */
module tb_sdd_decoder
	import sdd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_in, sys_rst_in, hsel, hwrite, hreadyout, hresp, step_out, dir_out;
	logic drive_en_out, step_w, dir_w, gate_w;
	logic [1:0] htrans;
	logic [2:0] pv;
	logic [4:0] ctl;
	logic [31:0] haddr, hwdata, hrdata, r, rnd;
	logic [31:0] q[$];
	logic [4:0] cfg[5] = '{5'h0c, 5'h0e, 5'h0d, 5'h01, 5'h1c};
	int n_mismatch, samples_checked, cyc, cnt[2];
	sdd_ctl_model u_ctl (.clk_in(sys_clk_in), .step_out(step_w), .dir_out(dir_w), .gate_out(gate_w));
	sdd_decoder u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .step_pulse_in(step_w),
		.dir_pin_in(dir_w), .drive_gate_in(gate_w), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .step_out(step_out), .dir_out(dir_out),
		.drive_en_out(drive_en_out));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One single AHB-Lite transfer, waiting on ready in both phases
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge sys_clk_in);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= SDD_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic push(input logic b);
		q.push_back({31'h0, b});
		cnt[b]++;
	endtask
	// Reference model of one pin move, then the move itself
	task automatic move(input int p, input logic v);
		if ((pv[2] ^ ctl[4]) && v != pv[p] && p < 2)
		begin
			if (!ctl[0] && p == 0 && v == !(ctl[1] ^ ctl[4]))
				push(pv[1]);
			else if (ctl[0] && v == ctl[2 + p])
				push(p[0]);
		end
		pv[p] = v;
		u_ctl.set_pin(p, v);
		cmp(32'(q.size()), 32'h0);
		// Drive enable pin follows the gate level, inverted for sourcing inputs
		if (p == 2)
			cmp({31'h0, drive_en_out}, {31'h0, pv[2] ^ ctl[4]});
	endtask
	// Each step must carry the predicted rotation sense
	always @(posedge sys_clk_in)
		if (step_out === 1'b1)
			cmp({31'h0, dir_out}, q.size() ? q.pop_front() : 32'hff);
	// Hang guard
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	// Main sequence: registers, then every mode with random directions
	initial
	begin
		{sys_rst_in, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
		{pv, ctl, rnd} = {3'h0, SDD_CTRL_RESET, 32'h0dcd8f98};
		repeat (3) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		ahb(1'b0, 32'h0, 32'h0, r);
		cmp(r, {27'h0, SDD_CTRL_RESET});
		ahb(1'b1, 32'h10, 32'hffffffff, r);
		ahb(1'b0, 32'h10, 32'h0, r);
		cmp(r, 32'h0);
		foreach (cfg[i])
		begin
			move(0, cfg[i][0] & !cfg[i][2]);
			move(1, cfg[i][0] & !cfg[i][3]);
			ctl = cfg[i];
			ahb(1'b1, 32'h0, {27'h1, ctl}, r);
			cnt = '{0, 0};
			move(2, !ctl[4]);
			ahb(1'b0, 32'h4, 32'h0, r);
			cmp(r & 32'h1, 32'h1);
			repeat (3)
			begin
				rnd = lfsr(rnd);
				move(1, rnd[0]);
				move(0, !pv[0]);
				move(0, !pv[0]);
			end
			move(2, ctl[4]);
			move(0, !pv[0]);
			move(0, !pv[0]);
			ahb(1'b0, 32'h8, 32'h0, r);
			cmp(r, cnt[0]);
			ahb(1'b0, 32'hc, 32'h0, r);
			cmp(r, cnt[1]);
		end
		print_verdict();
	end
endmodule
